// *** core/tti_consts.svh ***
// Functional notes
// - idle status high after five consecutive all-zero identifiers, low otherwise
// - change latched flag, bit 3, sets when stored identifier takes a new value
// - mismatch latched flag, bit 2, sets only on a 0-to-1 mismatch edge
// - unstable latched flag, bit 1, sets on a 0-to-1 unstable edge
// - idle latched flag, bit 0, sets on a 0-to-1 idle edge
// - interrupt needs flag set, its enable set, and the global port enable
// - received byte port read returns byte at pointer, then pointer wraps Fh->0h
// - expected byte port read or write advances its pointer, Fh wraps to 0h
// - live mismatch high while stored received and expected identifiers differ
// - unstable after eight identifiers matching neither previous nor stored one
// - 4-bit receive and expected pointers start at 0h and select next byte
`ifndef TTI_CONSTS_SVH
`define TTI_CONSTS_SVH

// register indices; the byte address is four times the index
`define TTI_IDX_POINTERS 32'h0000_00F2
`define TTI_IDX_LIVE 32'h0000_00F4
`define TTI_IDX_LATCHED 32'h0000_00F6
`define TTI_IDX_IRQ_EN 32'h0000_00F8
`define TTI_IDX_RX_BYTE 32'h0000_00FC
`define TTI_IDX_EXP_BYTE 32'h0000_00FE
`define TTI_IDX_GLOBAL_EN 32'h0000_0100
`define TTI_BYTE_ADDR(idx) ((idx) * 32'h0000_0004)

// pointer register fields
`define TTI_RX_PTR_LSB 0
`define TTI_EXP_PTR_LSB 8

// flag positions, shared by latched and enable registers and, except change, by the live register
`define TTI_BIT_IDLE 0
`define TTI_BIT_UNSTABLE 1
`define TTI_BIT_MISMATCH 2
`define TTI_BIT_CHANGE 3

`define TTI_FLAGS_RESET 4'h0
`define TTI_IRQ_EN_RESET 4'h0
`define TTI_PTR_RESET 4'h0
`define TTI_IDENT_RESET 128'h0

// identifier periods
`define TTI_IDLE_PERIODS 5
`define TTI_UNSTABLE_PERIODS 8

`endif

// *** core/tti_pkg.sv ***
package tti_pkg;

  typedef enum logic {
    TTI_BUS_ADDR,
    TTI_BUS_DATA
  } tti_bus_state_t;

  typedef logic [3:0] tti_ptr_t;
  typedef logic [127:0] tti_ident_t;

endpackage : tti_pkg

// *** core/tti_flag_latch.sv ***
module tti_flag_latch #(
  parameter bit EDGE = 1'b1
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic cond,
  input wire logic clr,
  output logic flag
);

  logic cond_d_reg;
  logic cond_d_next;
  logic flag_reg;
  logic flag_next;
  logic set;

  // set beats a clear arriving in the same cycle
  always_comb begin
    cond_d_next = cond;
    set = EDGE ? (cond & ~cond_d_reg) : cond;
    flag_next = set | (flag_reg & ~clr);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cond_d_reg <= 1'b0;
      flag_reg <= 1'b0;
    end else begin
      cond_d_reg <= cond_d_next;
      flag_reg <= flag_next;
    end
  end

  assign flag = flag_reg;

endmodule : tti_flag_latch

// *** core/tti_rx_trace.sv ***
`include "tti_consts.svh"

module tti_rx_trace
  import tti_pkg::*;
#(
  parameter int IDLE_PERIODS = `TTI_IDLE_PERIODS,
  parameter int UNSTABLE_PERIODS = `TTI_UNSTABLE_PERIODS
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic rx_byte_valid,
  input wire logic [7:0] rx_byte_data,
  input wire logic rx_ident_start,
  output logic idle_ident_status,
  output logic ident_mismatch_status,
  output logic ident_unstable_status,
  output logic irq
);

  ////////////////////////////////////////////////////////////////////////////
  // identifier assembly and supervision

  tti_ptr_t pos_reg;
  tti_ptr_t pos_next;
  tti_ident_t asm_reg;
  tti_ident_t asm_next;
  logic done_reg;
  logic done_next;
  tti_ident_t prev_reg;
  tti_ident_t prev_next;
  tti_ident_t cur_reg;
  tti_ident_t cur_next;
  logic [3:0] idle_cnt_reg;
  logic [3:0] idle_cnt_next;
  logic [3:0] unst_cnt_reg;
  logic [3:0] unst_cnt_next;
  logic idle_reg;
  logic idle_next;
  logic unst_reg;
  logic unst_next;
  logic mism_reg;
  logic mism_next;
  logic change_reg;
  logic change_next;
  tti_ident_t exp_reg;

  always_comb begin
    pos_next = pos_reg;
    asm_next = asm_reg;
    done_next = 1'b0;
    if (rx_byte_valid) begin
      if (rx_ident_start) begin
        asm_next[7:0] = rx_byte_data;
        pos_next = 4'h1;
      end else begin
        asm_next[{pos_reg, 3'b000} +: 8] = rx_byte_data;
        pos_next = pos_reg + 4'h1;
        done_next = (pos_reg == 4'hF);
      end
    end
  end

  // done_reg marks a full identifier in asm_reg; a new byte 0 may land on
  // the same edge, so everything below reads asm_reg only in that cycle
  always_comb begin
    prev_next = prev_reg;
    cur_next = cur_reg;
    idle_cnt_next = idle_cnt_reg;
    unst_cnt_next = unst_cnt_reg;
    change_next = 1'b0;
    if (done_reg) begin
      prev_next = asm_reg;
      if (asm_reg == 128'h0) begin
        if (idle_cnt_reg < 4'(IDLE_PERIODS)) begin
          idle_cnt_next = idle_cnt_reg + 4'h1;
        end
      end else begin
        idle_cnt_next = 4'h0;
      end
      // accept an identifier seen twice in a row
      if (asm_reg == prev_reg && asm_reg != cur_reg) begin
        cur_next = asm_reg;
        change_next = 1'b1;
      end
      if (asm_reg != prev_reg && asm_reg != cur_reg) begin
        if (unst_cnt_reg < 4'(UNSTABLE_PERIODS)) begin
          unst_cnt_next = unst_cnt_reg + 4'h1;
        end
      end else begin
        unst_cnt_next = 4'h0;
      end
    end
    idle_next = (idle_cnt_next >= 4'(IDLE_PERIODS));
    unst_next = (unst_cnt_next >= 4'(UNSTABLE_PERIODS));
    mism_next = (cur_reg != exp_reg);
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_reg <= `TTI_PTR_RESET;
      asm_reg <= `TTI_IDENT_RESET;
      done_reg <= 1'b0;
      prev_reg <= `TTI_IDENT_RESET;
      cur_reg <= `TTI_IDENT_RESET;
      idle_cnt_reg <= 4'h0;
      unst_cnt_reg <= 4'h0;
      idle_reg <= 1'b0;
      unst_reg <= 1'b0;
      mism_reg <= 1'b0;
      change_reg <= 1'b0;
    end else begin
      pos_reg <= pos_next;
      asm_reg <= asm_next;
      done_reg <= done_next;
      prev_reg <= prev_next;
      cur_reg <= cur_next;
      idle_cnt_reg <= idle_cnt_next;
      unst_cnt_reg <= unst_cnt_next;
      idle_reg <= idle_next;
      unst_reg <= unst_next;
      mism_reg <= mism_next;
      change_reg <= change_next;
    end
  end

  assign idle_ident_status = idle_reg;
  assign ident_unstable_status = unst_reg;
  assign ident_mismatch_status = mism_reg;

  ////////////////////////////////////////////////////////////////////////////
  // latched flags

  logic [3:0] live_vec;
  logic [3:0] flag_vec;
  logic [3:0] clr_vec;

  assign live_vec = {change_reg, mism_reg, unst_reg, idle_reg};

  for (genvar i = 0; i < 4; i++) begin : g_flag
    tti_flag_latch #(
      .EDGE(i != `TTI_BIT_CHANGE)
    ) u_flag (
      .hclk(hclk),
      .hresetn(hresetn),
      .cond(live_vec[i]),
      .clr(clr_vec[i]),
      .flag(flag_vec[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave, one wait state on every transfer

  tti_bus_state_t state_reg;
  tti_bus_state_t state_next;
  logic ready_reg;
  logic ready_next;
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;
  logic [31:0] addr_reg;
  logic [31:0] addr_next;
  logic write_reg;
  logic write_next;
  tti_ptr_t rx_ptr_reg;
  tti_ptr_t rx_ptr_next;
  tti_ptr_t exp_ptr_reg;
  tti_ptr_t exp_ptr_next;
  tti_ident_t exp_next;
  logic [3:0] irq_en_reg;
  logic [3:0] irq_en_next;
  logic gen_en_reg;
  logic gen_en_next;
  logic irq_reg;
  logic irq_next;

  // the wait state lets hrdata come from a flop and keeps the pointer
  // side effects to exactly one per transfer
  always_comb begin
    state_next = state_reg;
    ready_next = ready_reg;
    rdata_next = rdata_reg;
    addr_next = addr_reg;
    write_next = write_reg;
    rx_ptr_next = rx_ptr_reg;
    exp_ptr_next = exp_ptr_reg;
    exp_next = exp_reg;
    irq_en_next = irq_en_reg;
    gen_en_next = gen_en_reg;
    clr_vec = 4'h0;
    case (state_reg)
      TTI_BUS_ADDR: begin
        if (hsel && htrans[1] && hready) begin
          addr_next = {haddr[31:2], 2'b00};
          write_next = hwrite;
          state_next = TTI_BUS_DATA;
          ready_next = 1'b0;
        end
      end
      TTI_BUS_DATA: begin
        state_next = TTI_BUS_ADDR;
        ready_next = 1'b1;
        rdata_next = 32'h0000_0000;
        if (addr_reg == `TTI_BYTE_ADDR(`TTI_IDX_POINTERS)) begin
          if (write_reg) begin
            rx_ptr_next = hwdata[`TTI_RX_PTR_LSB +: 4];
            exp_ptr_next = hwdata[`TTI_EXP_PTR_LSB +: 4];
          end else begin
            rdata_next[`TTI_RX_PTR_LSB +: 4] = rx_ptr_reg;
            rdata_next[`TTI_EXP_PTR_LSB +: 4] = exp_ptr_reg;
          end
        end else if (addr_reg == `TTI_BYTE_ADDR(`TTI_IDX_LIVE)) begin
          rdata_next[2:0] = {mism_reg, unst_reg, idle_reg};
        end else if (addr_reg == `TTI_BYTE_ADDR(`TTI_IDX_LATCHED)) begin
          if (write_reg) begin
            clr_vec = hwdata[3:0];
          end else begin
            rdata_next[3:0] = flag_vec;
          end
        end else if (addr_reg == `TTI_BYTE_ADDR(`TTI_IDX_IRQ_EN)) begin
          if (write_reg) begin
            irq_en_next = hwdata[3:0];
          end else begin
            rdata_next[3:0] = irq_en_reg;
          end
        end else if (addr_reg == `TTI_BYTE_ADDR(`TTI_IDX_RX_BYTE)) begin
          // writes here are dropped on purpose
          if (!write_reg) begin
            rdata_next[7:0] = cur_reg[{rx_ptr_reg, 3'b000} +: 8];
            rx_ptr_next = rx_ptr_reg + 4'h1;
          end
        end else if (addr_reg == `TTI_BYTE_ADDR(`TTI_IDX_EXP_BYTE)) begin
          if (write_reg) begin
            exp_next[{exp_ptr_reg, 3'b000} +: 8] = hwdata[7:0];
          end else begin
            rdata_next[7:0] = exp_reg[{exp_ptr_reg, 3'b000} +: 8];
          end
          exp_ptr_next = exp_ptr_reg + 4'h1;
        end else if (addr_reg == `TTI_BYTE_ADDR(`TTI_IDX_GLOBAL_EN)) begin
          if (write_reg) begin
            gen_en_next = hwdata[0];
          end else begin
            rdata_next[0] = gen_en_reg;
          end
        end
      end
      default: begin
        state_next = TTI_BUS_ADDR;
        ready_next = 1'b1;
      end
    endcase
    irq_next = (|(flag_vec & irq_en_reg)) & gen_en_reg;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_reg <= TTI_BUS_ADDR;
      ready_reg <= 1'b1;
      rdata_reg <= 32'h0000_0000;
      addr_reg <= 32'h0000_0000;
      write_reg <= 1'b0;
      rx_ptr_reg <= `TTI_PTR_RESET;
      exp_ptr_reg <= `TTI_PTR_RESET;
      exp_reg <= `TTI_IDENT_RESET;
      irq_en_reg <= `TTI_IRQ_EN_RESET;
      gen_en_reg <= 1'b0;
      irq_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      ready_reg <= ready_next;
      rdata_reg <= rdata_next;
      addr_reg <= addr_next;
      write_reg <= write_next;
      rx_ptr_reg <= rx_ptr_next;
      exp_ptr_reg <= exp_ptr_next;
      exp_reg <= exp_next;
      irq_en_reg <= irq_en_next;
      gen_en_reg <= gen_en_next;
      irq_reg <= irq_next;
    end
  end

  // hsize unused: only whole-word transfers are supported
  logic hresp_reg;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hresp_reg <= 1'b0;
    end else begin
      hresp_reg <= 1'b0;
    end
  end

  assign hreadyout = ready_reg;
  assign hresp = hresp_reg;
  assign hrdata = rdata_reg;
  assign irq = irq_reg;

endmodule : tti_rx_trace

// *** tb/tti_ident_src.sv ***
module tti_ident_src (
  input wire logic hclk,
  input wire logic go,
  input wire logic [7:0] base,
  output logic valid,
  output logic start,
  output logic [7:0] data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [4:0] k = 5'h10;
  logic [4:0] n;
  initial valid = 1'b0;
  initial start = 1'b0;
  initial data = 8'h00;
  assign n = go ? 5'h00 : k + 5'h01;
  // byte 0 goes first; line is scrambled between identifiers
  always @(posedge hclk) begin
    k <= (n < 5'h10) ? n : 5'h10;
    valid <= n < 5'h10;
    start <= n == 5'h00;
    data <= (n < 5'h10) ? ((base != 8'h00) ? base + n[3:0] : 8'h00) : ~data;
  end
endmodule : tti_ident_src

// *** tb/tti_rx_trace_chk.sv ***
module tti_rx_trace_chk (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic rx_byte_valid,
  input wire logic rx_ident_start,
  input wire logic idle_ident_status,
  input wire logic ident_mismatch_status,
  input wire logic ident_unstable_status,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] pos_reg, pos_next, cnt_reg, cnt_next;
  logic done_reg, done_next, wr_reg, wr_next, acc;
  assign acc = hsel && htrans[1] && hready && hreadyout;
  // cnt marks a short span after any cause of a status or irq change
  always_comb begin
    pos_next = pos_reg;
    if (rx_byte_valid) pos_next = rx_ident_start ? 4'h1 : pos_reg + 4'h1;
    done_next = rx_byte_valid && !rx_ident_start && pos_reg == 4'hF;
    wr_next = acc && hwrite;
    cnt_next = cnt_reg - {3'h0, cnt_reg != 4'h0};
    if (done_reg || wr_reg) cnt_next = 4'h8;
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pos_reg <= 4'h0;
      cnt_reg <= 4'h0;
      done_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else begin
      pos_reg <= pos_next;
      cnt_reg <= cnt_next;
      done_reg <= done_next;
      wr_reg <= wr_next;
    end
  end
  ////////////////////////////////////////
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_acc;
    hsel && htrans[1] && hready && hreadyout;
  endsequence
  sequence s_wait;
    !hreadyout ##1 hreadyout;
  endsequence
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not okay");
  a_one_wait: assert property (s_acc |=> s_wait)
    else $error("wait state count wrong");
  a_no_stall: assert property (hreadyout && !acc |=> hreadyout)
    else $error("wait state without transfer");
  a_rdata_held: assert property (hreadyout |=> $stable(hrdata))
    else $error("hrdata changed outside read");
  a_idle_at_ident: assert property (!$past(done_reg) &&
    !$past(done_reg, 2) |-> $stable(idle_ident_status))
    else $error("idle status moved without identifier");
  a_unst_at_ident: assert property (!$past(done_reg) &&
    !$past(done_reg, 2) |-> $stable(ident_unstable_status))
    else $error("unstable status moved without identifier");
  a_mism_cause: assert property (
    $changed(ident_mismatch_status) |-> cnt_reg != 4'h0)
    else $error("mismatch moved without cause");
  a_irq_cause: assert property ($changed(irq) |-> cnt_reg != 4'h0)
    else $error("irq moved without cause");
endmodule : tti_rx_trace_chk

bind tti_rx_trace tti_rx_trace_chk i_chk (
  .hclk(hclk),
  .hresetn(hresetn),
  .hsel(hsel),
  .htrans(htrans),
  .hwrite(hwrite),
  .hready(hready),
  .hreadyout(hreadyout),
  .hresp(hresp),
  .hrdata(hrdata),
  .rx_byte_valid(rx_byte_valid),
  .rx_ident_start(rx_ident_start),
  .idle_ident_status(idle_ident_status),
  .ident_mismatch_status(ident_mismatch_status),
  .ident_unstable_status(ident_unstable_status),
  .irq(irq)
);

// *** tb/tti_rx_trace_test.sv ***
`include "tti_consts.svh"

module tti_rx_trace_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [31:0] A_PTR = `TTI_BYTE_ADDR(`TTI_IDX_POINTERS);
  localparam logic [31:0] A_LIV = `TTI_BYTE_ADDR(`TTI_IDX_LIVE);
  localparam logic [31:0] A_LAT = `TTI_BYTE_ADDR(`TTI_IDX_LATCHED);
  localparam logic [31:0] A_EN = `TTI_BYTE_ADDR(`TTI_IDX_IRQ_EN);
  localparam logic [31:0] A_RX = `TTI_BYTE_ADDR(`TTI_IDX_RX_BYTE);
  localparam logic [31:0] A_EXP = `TTI_BYTE_ADDR(`TTI_IDX_EXP_BYTE);
  localparam logic [31:0] A_GLB = `TTI_BYTE_ADDR(`TTI_IDX_GLOBAL_EN);
  localparam logic [31:0] A_UNM = 32'h0000_03E8;
  typedef struct {logic [31:0] a; logic w; logic [31:0] d, e;} tti_row_t;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, go;
  logic rxv, rxs, idl, mis, uns, irq;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, r;
  logic [7:0] rxd, sd;
  int num_errors = 0;
  int n_compared = 0;
  tti_row_t rows[9] = '{'{A_EN, 0, 0, 0}, '{A_EN, 1, 32'hF, 0},
    '{A_EN, 0, 0, 32'hF}, '{A_UNM, 1, 32'hFFFF_FFFF, 0}, '{A_UNM, 0, 0, 0},
    '{A_LAT, 0, 0, 0}, '{A_LIV, 0, 0, 0}, '{A_GLB, 1, 1, 0},
    '{A_PTR, 0, 0, 0}};
  tti_rx_trace i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hresp(hresp), .hrdata(hrdata), .rx_byte_valid(rxv),
    .rx_byte_data(rxd), .rx_ident_start(rxs), .idle_ident_status(idl),
    .ident_mismatch_status(mis), .ident_unstable_status(uns), .irq(irq));
  tti_ident_src i_src (.hclk(hclk), .go(go), .base(sd), .valid(rxv),
    .start(rxs), .data(rxd));
  ////////////////////////////////////////
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  task finish_test;
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : finish_test
  task chk(input string s, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      num_errors++;
      $display("mismatch %s exp %h got %h", s, e, g);
    end
  endtask : chk
  task bus(input logic [31:0] a, input logic w, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : bus
  task rd(input string s, input logic [31:0] a, e);
    bus(a, 1'b0, 32'h0);
    chk(s, e, r);
  endtask : rd
  // fixed wait covers 16 bytes plus the status pipeline
  task send(input logic [7:0] s);
    sd <= s;
    go <= 1'b1;
    @(posedge hclk);
    go <= 1'b0;
    repeat (22) @(posedge hclk);
  endtask : send
  function logic [31:0] fb(input logic [7:0] s, input int k);
    return {24'h0, (s != 8'h00) ? s + k[7:0] : 8'h00};
  endfunction : fb
  ////////////////////////////////////////
  initial begin
    repeat (5000) @(posedge hclk);
    num_errors++;
    finish_test();
  end
  initial begin
    {hresetn, hsel, hwrite, go, htrans, haddr, hwdata, sd} = '0;
    hsize = 3'h2;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    foreach (rows[i]) begin
      if (rows[i].w) bus(rows[i].a, 1'b1, rows[i].d);
      else rd("reg", rows[i].a, rows[i].e);
    end
    $display("test registers done");
    for (int k = 0; k < 16; k++) bus(A_EXP, 1'b1, fb(8'h40, k));
    rd("pointers", A_PTR, 32'h0);
    rd("live", A_LIV, 32'h4);
    chk("mismatch", 1, mis);
    rd("latched", A_LAT, 32'h4);
    chk("irq", 1, irq);
    bus(A_GLB, 1'b1, 32'h0);
    repeat (2) @(posedge hclk);
    chk("irq", 0, irq);
    bus(A_GLB, 1'b1, 32'h1);
    bus(A_LAT, 1'b1, 32'h4);
    rd("latched", A_LAT, 32'h0);
    chk("irq", 0, irq);
    for (int k = 0; k < 16; k++) rd("exp", A_EXP, fb(8'h40, k));
    $display("test expected done");
    send(8'h40);
    send(8'h40);
    rd("latched", A_LAT, 32'h8);
    rd("live", A_LIV, 32'h0);
    chk("mismatch", 0, mis);
    for (int k = 0; k < 17; k++) rd("rx", A_RX, fb(8'h40, k % 16));
    bus(A_RX, 1'b1, 32'hFF);
    rd("pointers", A_PTR, 32'h1);
    rd("rx", A_RX, fb(8'h40, 1));
    bus(A_PTR, 1'b1, 32'h0000_0305);
    rd("pointers", A_PTR, 32'h0000_0305);
    rd("rx", A_RX, fb(8'h40, 5));
    rd("exp", A_EXP, fb(8'h40, 3));
    rd("pointers", A_PTR, 32'h0000_0406);
    bus(A_LAT, 1'b1, 32'hF);
    $display("test received done");
    for (int i = 0; i < 5; i++) begin
      send(8'h00);
      chk("idle", i == 4, idl);
    end
    rd("latched", A_LAT, 32'hD);
    bus(A_LAT, 1'b1, 32'hF);
    for (int i = 1; i < 9; i++) begin
      send(i[7:0]);
      chk("unstable", i == 8, uns);
    end
    rd("latched", A_LAT, 32'h2);
    chk("irq", 1, irq);
    $display("test events done");
    hresetn <= 1'b0;
    repeat (2) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    rd("enable", A_EN, 32'h0);
    chk("unstable", 0, uns);
    chk("idle", 0, idl);
    chk("mismatch", 0, mis);
    chk("irq", 0, irq);
    $display("test reset done");
    finish_test();
  end
endmodule : tti_rx_trace_test
